//--- logic/target_cond_pkg.sv
// Purpose: shared constants of the target value conditioning path
// Assumes: AHB-Lite register bus, 32-bit words, one register per word
// Notes:   register positions are word indices, byte address = 4 * index
package target_cond_pkg;

	// ---------------------------------------------------------------
	// register word indices
	// ---------------------------------------------------------------
	localparam logic [29:0] IDX_TARGET_INPUT   = 30'h1C2;
	localparam logic [29:0] IDX_SOURCE_SELECT  = 30'h1C4;
	localparam logic [29:0] IDX_MULTIPLIER     = 30'h1C5;
	localparam logic [29:0] IDX_DIVISOR        = 30'h1C6;
	localparam logic [29:0] IDX_POST_OFFSET    = 30'h1C7;
	localparam logic [29:0] IDX_LOWER_LIMIT    = 30'h1C8;
	localparam logic [29:0] IDX_UPPER_LIMIT    = 30'h1CA;
	localparam logic [29:0] IDX_DEADBAND       = 30'h1CC;
	localparam logic [29:0] IDX_SETPOINT_VIEW  = 30'h1CE;
	localparam logic [29:0] IDX_ENCODER_MODE   = 30'h1D0;
	localparam logic [29:0] IDX_ENCODER_COUNT  = 30'h1D1;

	// ---------------------------------------------------------------
	// source selector codes
	// ---------------------------------------------------------------
	localparam logic [15:0] SEL_REGISTER = 16'h0000;
	localparam logic [15:0] SEL_ANALOG_1 = 16'h0001;
	localparam logic [15:0] SEL_ANALOG_2 = 16'h0002;
	localparam logic [15:0] SEL_ANALOG_3 = 16'h0003;
	localparam logic [15:0] SEL_ANALOG_4 = 16'h0004;
	localparam logic [15:0] SEL_ENCODER  = 16'h0005;
	localparam logic [15:0] SEL_PULSE    = 16'h0006;

	// ---------------------------------------------------------------
	// encoder mode field
	// ---------------------------------------------------------------
	localparam int          ENC_MODE_BIT  = 0;
	localparam logic        ENC_QUADRATURE = 1'b0;
	localparam logic        ENC_STEP_DIR   = 1'b1;

	// ---------------------------------------------------------------
	// reset values
	// ---------------------------------------------------------------
	localparam logic [31:0] RST_TARGET_INPUT = 32'h0000_0000;
	localparam logic [15:0] RST_SELECT       = 16'h0000;
	localparam logic [15:0] RST_MULTIPLIER   = 16'h0001;
	localparam logic [15:0] RST_DIVISOR      = 16'h0001;
	localparam logic [15:0] RST_POST_OFFSET  = 16'h0000;
	localparam logic [31:0] RST_LOWER_LIMIT  = 32'h8000_0000;
	localparam logic [31:0] RST_UPPER_LIMIT  = 32'h7FFF_FFFF;
	localparam logic [15:0] RST_DEADBAND     = 16'h0000;
	localparam logic [31:0] RST_WORD         = 32'h0000_0000;

	// ---------------------------------------------------------------
	// bus encodings
	// ---------------------------------------------------------------
	localparam int          HTRANS_ACTIVE_BIT = 1;
	localparam logic        HRESP_OKAY        = 1'b0;

endpackage : target_cond_pkg

//--- logic/target_conditioning.sv
// Purpose: selects, scales, offsets, deadbands and limits the setpoint
// Assumes: analog samples come from logic on clk_in; encoder pins do not
// Notes:   six-stage pipeline from source to regulator output
//
// Our own choice: register access over AHB-Lite.
`timescale 1ns/10ps

module target_conditioning (
	input  wire logic        clk_in,
	input  wire logic        rst_in,
	input  wire logic        ce_in,
	input  wire logic        hsel_in,
	input  wire logic [31:0] haddr_in,
	input  wire logic [1:0]  htrans_in,
	input  wire logic        hwrite_in,
	input  wire logic [2:0]  hsize_in,
	input  wire logic [31:0] hwdata_in,
	input  wire logic        hready_in,
	output logic      [31:0] hrdata_out,
	output logic             hreadyout_out,
	output logic             hresp_out,
	input  wire logic [15:0] analog_channel_one_in,
	input  wire logic [15:0] analog_channel_two_in,
	input  wire logic [15:0] analog_channel_three_in,
	input  wire logic [15:0] analog_channel_four_in,
	input  wire logic        enc_a_in,
	input  wire logic        enc_b_in,
	output logic      [31:0] target_to_regulator_out
);
	import target_cond_pkg::*;

	// ---------------------------------------------------------------
	// registers
	// ---------------------------------------------------------------
	logic        [31:0] target_input_r;
	logic        [15:0] select_r;
	logic        [15:0] mul_r;
	logic        [15:0] div_r;
	logic        [15:0] offset_r;
	logic        [31:0] lower_r;
	logic        [31:0] upper_r;
	logic        [15:0] deadband_r;
	logic               enc_mode_r;
	logic        [31:0] enc_count_r;

	logic               wr_pend_r;
	logic        [29:0] wr_idx_r;
	logic        [31:0] rd_word;
	logic               addr_ok;
	logic               take;

	logic        [1:0]  a_sync_r;
	logic        [1:0]  b_sync_r;
	logic               a_prev_r;
	logic               b_prev_r;

	logic signed [31:0] raw_r;
	logic               raw_valid_r;
	logic signed [47:0] prod_r;
	logic               prod_valid_r;
	logic signed [47:0] quot_full;
	logic signed [31:0] quot_r;
	logic signed [31:0] offs_r;
	logic signed [31:0] hyst_r;
	logic signed [32:0] diff;
	logic        [32:0] abs_diff;
	logic        [32:0] db_eff;
	logic               pass_change;

	// ---------------------------------------------------------------
	// bus slave
	// ---------------------------------------------------------------
	assign take    = hsel_in && htrans_in[HTRANS_ACTIVE_BIT] && hready_in;
	assign addr_ok = (haddr_in[1:0] == 2'h0);

	always_comb begin
		rd_word = RST_WORD;
		if (addr_ok) begin
			unique case (haddr_in[31:2])
				IDX_TARGET_INPUT:  rd_word = target_input_r;
				IDX_SOURCE_SELECT: rd_word = {16'h0000, select_r};
				IDX_MULTIPLIER:    rd_word = {16'h0000, mul_r};
				IDX_DIVISOR:       rd_word = {16'h0000, div_r};
				IDX_POST_OFFSET:   rd_word = {16'h0000, offset_r};
				IDX_LOWER_LIMIT:   rd_word = lower_r;
				IDX_UPPER_LIMIT:   rd_word = upper_r;
				IDX_DEADBAND:      rd_word = {16'h0000, deadband_r};
				IDX_SETPOINT_VIEW: rd_word = target_to_regulator_out;
				IDX_ENCODER_MODE:  rd_word = {31'h0, enc_mode_r};
				IDX_ENCODER_COUNT: rd_word = enc_count_r;
				default:           rd_word = RST_WORD;
			endcase
		end
	end

	// read data is loaded at the address phase so the data phase has no wait
	always_ff @(posedge clk_in) begin
		if (rst_in) begin
			hrdata_out    <= RST_WORD;
			hreadyout_out <= 1'b1;
			hresp_out     <= HRESP_OKAY;
		end else if (ce_in) begin
			hreadyout_out <= 1'b1;
			hresp_out     <= HRESP_OKAY;
			if (take && !hwrite_in)
				hrdata_out <= rd_word;
		end
	end

	always_ff @(posedge clk_in) begin
		if (rst_in) begin
			wr_pend_r <= 1'b0;
			wr_idx_r  <= 30'h0;
		end else if (ce_in) begin
			wr_pend_r <= take && hwrite_in && addr_ok;
			if (take)
				wr_idx_r <= haddr_in[31:2];
		end
	end

	// writes to read-only or unmapped words are dropped, answer stays OKAY
	always_ff @(posedge clk_in) begin
		if (rst_in) begin
			target_input_r <= RST_TARGET_INPUT;
			select_r       <= RST_SELECT;
			mul_r          <= RST_MULTIPLIER;
			div_r          <= RST_DIVISOR;
			offset_r       <= RST_POST_OFFSET;
			lower_r        <= RST_LOWER_LIMIT;
			upper_r        <= RST_UPPER_LIMIT;
			deadband_r     <= RST_DEADBAND;
			enc_mode_r     <= ENC_QUADRATURE;
		end else if (ce_in && wr_pend_r) begin
			unique case (wr_idx_r)
				IDX_TARGET_INPUT:  target_input_r <= hwdata_in;
				IDX_SOURCE_SELECT: select_r       <= hwdata_in[15:0];
				IDX_MULTIPLIER:    mul_r          <= hwdata_in[15:0];
				IDX_DIVISOR:       div_r          <= hwdata_in[15:0];
				IDX_POST_OFFSET:   offset_r       <= hwdata_in[15:0];
				IDX_LOWER_LIMIT:   lower_r        <= hwdata_in;
				IDX_UPPER_LIMIT:   upper_r        <= hwdata_in;
				IDX_DEADBAND:      deadband_r     <= hwdata_in[15:0];
				IDX_ENCODER_MODE:  enc_mode_r <= hwdata_in[ENC_MODE_BIT];
				default:           ;
			endcase
		end
	end

	// ---------------------------------------------------------------
	// encoder interface
	// ---------------------------------------------------------------
	always_ff @(posedge clk_in) begin
		if (rst_in) begin
			a_sync_r <= 2'h0;
			b_sync_r <= 2'h0;
			a_prev_r <= 1'b0;
			b_prev_r <= 1'b0;
		end else if (ce_in) begin
			a_sync_r <= {a_sync_r[0], enc_a_in};
			b_sync_r <= {b_sync_r[0], enc_b_in};
			a_prev_r <= a_sync_r[1];
			b_prev_r <= b_sync_r[1];
		end
	end

	// a double edge in quadrature mode is a lost step and is ignored
	always_ff @(posedge clk_in) begin
		if (rst_in) begin
			enc_count_r <= RST_WORD;
		end else if (ce_in) begin
			if (enc_mode_r == ENC_STEP_DIR) begin
				if (a_sync_r[1] && !a_prev_r)
					enc_count_r <= b_sync_r[1] ? enc_count_r + 32'h1
					                           : enc_count_r - 32'h1;
			end else if ((a_sync_r[1] ^ a_prev_r) !=
			             (b_sync_r[1] ^ b_prev_r)) begin
				enc_count_r <= (a_prev_r ^ b_sync_r[1]) ? enc_count_r - 32'h1
				                                        : enc_count_r + 32'h1;
			end
		end
	end

	// ---------------------------------------------------------------
	// source selection
	// ---------------------------------------------------------------
	always_ff @(posedge clk_in) begin
		if (rst_in) begin
			raw_r       <= RST_WORD;
			raw_valid_r <= 1'b0;
		end else if (ce_in) begin
			raw_valid_r <= 1'b1;
			unique case (select_r)
				SEL_REGISTER: raw_r <= target_input_r;
				SEL_ANALOG_1: raw_r <= {16'h0, analog_channel_one_in};
				SEL_ANALOG_2: raw_r <= {16'h0, analog_channel_two_in};
				SEL_ANALOG_3: raw_r <= {16'h0, analog_channel_three_in};
				SEL_ANALOG_4: raw_r <= {16'h0, analog_channel_four_in};
				SEL_ENCODER:  raw_r <= enc_count_r;
				default:      raw_valid_r <= 1'b0;
			endcase
		end
	end

	// ---------------------------------------------------------------
	// scale, offset, deadband, limits
	// ---------------------------------------------------------------
	assign quot_full = prod_r / 48'(signed'(div_r));

	always_ff @(posedge clk_in) begin
		if (rst_in) begin
			prod_r       <= 48'h0;
			prod_valid_r <= 1'b0;
			quot_r       <= RST_WORD;
			offs_r       <= RST_WORD;
		end else if (ce_in) begin
			prod_r       <= 48'(raw_r) * 48'(signed'(mul_r));
			prod_valid_r <= raw_valid_r;
			// an undefined source or zero divisor keeps the last quotient
			if (prod_valid_r && div_r != 16'h0)
				quot_r <= quot_full[31:0];
			offs_r <= quot_r + 32'(signed'(offset_r));
		end
	end

	// a negative deadband acts as zero
	assign diff        = 33'(offs_r) - 33'(hyst_r);
	assign abs_diff    = diff[32] ? 33'(-diff) : 33'(diff);
	assign db_eff      = deadband_r[15] ? 33'h0 : {17'h0, deadband_r};
	assign pass_change = (abs_diff >= db_eff);

	always_ff @(posedge clk_in) begin
		if (rst_in) begin
			hyst_r <= RST_WORD;
		end else if (ce_in && pass_change) begin
			hyst_r <= offs_r;
		end
	end

	// limits stand last so the regulator sees no out-of-range value unless lower_r lies above upper_r
	always_ff @(posedge clk_in) begin
		if (rst_in) begin
			target_to_regulator_out <= RST_WORD;
		end else if (ce_in) begin
			if (hyst_r < signed'(lower_r))
				target_to_regulator_out <= lower_r;
			else if (hyst_r > signed'(upper_r))
				target_to_regulator_out <= upper_r;
			else
				target_to_regulator_out <= hyst_r;
		end
	end

	// ---------------------------------------------------------------
	// assertions
	// ---------------------------------------------------------------
	AST_SEL_REGISTER: assert property (@(posedge clk_in) disable iff (rst_in)
		ce_in && select_r == SEL_REGISTER |=> raw_r == $past(target_input_r))
		else $error("register source not routed");

	AST_SEL_ANALOG: assert property (@(posedge clk_in) disable iff (rst_in)
		ce_in && select_r == SEL_ANALOG_3
		|=> raw_r == {16'h0, $past(analog_channel_three_in)} && raw_valid_r)
		else $error("analog source not routed");

	AST_SEL_ENCODER: assert property (@(posedge clk_in) disable iff (rst_in)
		ce_in && select_r == SEL_ENCODER |=> raw_r == $past(enc_count_r))
		else $error("encoder source not routed");

	AST_STEP_COUNT: assert property (@(posedge clk_in) disable iff (rst_in)
		ce_in && enc_mode_r == ENC_STEP_DIR && a_sync_r[1] && !a_prev_r
		&& b_sync_r[1] |=> enc_count_r == $past(enc_count_r) + 32'h1)
		else $error("step did not count up");

	AST_PULSE_NONE: assert property (@(posedge clk_in) disable iff (rst_in)
		ce_in && select_r == SEL_PULSE |=> !raw_valid_r ##1 ce_in |=> $stable(quot_r))
		else $error("pulse source produced a target");

	AST_MULTIPLY: assert property (@(posedge clk_in) disable iff (rst_in)
		ce_in |=> prod_r == $past(raw_r) * signed'($past(mul_r)))
		else $error("product wrong");

	AST_DIV_ZERO: assert property (@(posedge clk_in) disable iff (rst_in)
		ce_in && div_r == 16'h0 |=> $stable(quot_r))
		else $error("zero divisor changed target");

	AST_OFFSET: assert property (@(posedge clk_in) disable iff (rst_in)
		ce_in |=> offs_r == $past(quot_r) + 32'(signed'($past(offset_r))))
		else $error("offset wrong");

	AST_LOWER: assert property (@(posedge clk_in) disable iff (rst_in)
		ce_in && signed'(lower_r) <= signed'(upper_r)
		|=> signed'(target_to_regulator_out) >= signed'($past(lower_r)))
		else $error("target below lower limit");

	AST_UPPER: assert property (@(posedge clk_in) disable iff (rst_in)
		ce_in && signed'(lower_r) <= signed'(upper_r)
		|=> signed'(target_to_regulator_out) <= signed'($past(upper_r)))
		else $error("target above upper limit");

	AST_DEADBAND: assert property (@(posedge clk_in) disable iff (rst_in)
		ce_in && !pass_change |=> $stable(hyst_r))
		else $error("small change passed deadband");

	AST_VIEW: assert property (@(posedge clk_in) disable iff (rst_in)
		ce_in && take && !hwrite_in && haddr_in == {IDX_SETPOINT_VIEW, 2'h0}
		|=> hrdata_out == $past(target_to_regulator_out))
		else $error("view register wrong");

	AST_ANALOG_ONE: assert property (
		@(posedge clk_in) disable iff (rst_in)
		ce_in && select_r == SEL_ANALOG_1
		|=> raw_r == {16'h0, $past(analog_channel_one_in)})
		else $error("analog one not routed");

	AST_ANALOG_FOUR: assert property (
		@(posedge clk_in) disable iff (rst_in)
		ce_in && select_r == SEL_ANALOG_4
		|=> raw_r == {16'h0, $past(analog_channel_four_in)})
		else $error("analog four not routed");

	AST_INPUT_UNUSED: assert property (
		@(posedge clk_in) disable iff (rst_in)
		ce_in && select_r != SEL_REGISTER && select_r <= SEL_ANALOG_4
		|=> raw_r[31:16] == 16'h0000)
		else $error("input register leaked into analog source");

	AST_INPUT_WRITE: assert property (
		@(posedge clk_in) disable iff (rst_in)
		ce_in && wr_pend_r && wr_idx_r == IDX_TARGET_INPUT
		|=> target_input_r == $past(hwdata_in))
		else $error("target input write lost");

	AST_PASS: assert property (
		@(posedge clk_in) disable iff (rst_in)
		ce_in && pass_change
		|=> hyst_r == $past(offs_r))
		else $error("large change not passed");

	AST_LOWER_WINS: assert property (
		@(posedge clk_in) disable iff (rst_in)
		ce_in && hyst_r < signed'(lower_r)
		|=> target_to_regulator_out == $past(lower_r))
		else $error("lower limit not applied");

endmodule : target_conditioning

//--- tb/tb_target_conditioning.sv
// Purpose: self-checking bench of the setpoint conditioning path
// Assumes: zero-wait AHB-Lite slave, six-stage pipeline to the output
// Notes:   expected values are worked out by hand, except the quadrature check, which starts from the count c0 read back
`timescale 1ns/10ps

`define CHK(nm, e, g) begin checks++; if ((g) !== (e)) begin fails++; \
	$display("MISMATCH %s expected %h seen %h", nm, e, g); end end

module tb_target_conditioning;
	import target_cond_pkg::*;

	// ---------------------------------------------------------------
	// stimulus and observation
	// ---------------------------------------------------------------
	logic        clk_in;
	logic        rst_in;
	logic        ce;
	logic        hsel;
	logic [31:0] haddr;
	logic [1:0]  htrans;
	logic        hwrite;
	logic [31:0] hwdata;
	logic [31:0] hrdata;
	wire  logic  hready;
	logic        hresp;
	logic [15:0] ain [4];
	logic        enc_a;
	logic        enc_b;
	logic [31:0] tgt;
	logic [31:0] q;
	logic [31:0] c0;
	int          fails;
	int          checks;
	int          cyc;

	target_conditioning dut (
		.clk_in(clk_in), .rst_in(rst_in), .ce_in(ce),
		.hsel_in(hsel), .haddr_in(haddr), .htrans_in(htrans),
		.hwrite_in(hwrite), .hsize_in(3'h2), .hwdata_in(hwdata),
		.hready_in(hready), .hrdata_out(hrdata),
		.hreadyout_out(hready), .hresp_out(hresp),
		.analog_channel_one_in(ain[0]), .analog_channel_two_in(ain[1]),
		.analog_channel_three_in(ain[2]), .analog_channel_four_in(ain[3]),
		.enc_a_in(enc_a), .enc_b_in(enc_b),
		.target_to_regulator_out(tgt)
	);

	// ---------------------------------------------------------------
	// bus master tasks
	// ---------------------------------------------------------------
	task automatic bus(input logic is_wr, input logic [29:0] idx,
		input logic [31:0] d, output logic [31:0] r);
		@(posedge clk_in);
		hsel <= 1'b1;
		htrans <= 2'h2;
		hwrite <= is_wr;
		haddr <= {idx, 2'h0};
		// only the bench timeout ends a wait for the slave
		do begin
			@(posedge clk_in);
		end while (hready !== 1'b1);
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwdata <= d;
		do begin
			@(posedge clk_in);
		end while (hready !== 1'b1);
		r = hrdata;
		`CHK("hresp", HRESP_OKAY, hresp)
	endtask : bus

	task automatic wr(input logic [29:0] idx, input logic [31:0] d);
		logic [31:0] r;
		bus(1'b1, idx, d, r);
	endtask : wr

	task automatic rd(input logic [29:0] idx, input logic [31:0] e,
		input string nm);
		logic [31:0] r;
		bus(1'b0, idx, 32'h0000_0000, r);
		`CHK(nm, e, r)
	endtask : rd

	// pipeline is six deep, encoder adds three; twelve covers both
	task automatic out_is(input logic [31:0] e, input string nm);
		repeat (12) @(posedge clk_in);
		`CHK(nm, e, tgt)
		rd(IDX_SETPOINT_VIEW, e, "view");
	endtask : out_is

	task automatic steps(input int n);
		repeat (n) begin
			repeat (3) @(posedge clk_in);
			enc_a <= 1'b1;
			repeat (3) @(posedge clk_in);
			enc_a <= 1'b0;
		end
	endtask : steps

	task automatic close_out;
		$display("checks %0d fails %0d", checks, fails);
		if (fails == 0 && checks > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask : close_out

	// ---------------------------------------------------------------
	// clock and hang guard
	// ---------------------------------------------------------------
	initial begin
		clk_in = 1'b0;
		forever #2.5 clk_in = ~clk_in;
	end

	always @(posedge clk_in) begin
		cyc++;
		if (cyc == 8000) begin
			fails++;
			close_out();
		end
	end

	// ---------------------------------------------------------------
	// tests
	// ---------------------------------------------------------------
	initial begin
		logic [29:0] ri [9];
		logic [31:0] rv [9];
		ri = '{IDX_TARGET_INPUT, IDX_SOURCE_SELECT, IDX_MULTIPLIER,
			IDX_DIVISOR, IDX_POST_OFFSET, IDX_LOWER_LIMIT,
			IDX_UPPER_LIMIT, IDX_DEADBAND, 30'h1C3};
		rv = '{RST_TARGET_INPUT, {16'h0, RST_SELECT}, {16'h0, RST_MULTIPLIER},
			{16'h0, RST_DIVISOR}, {16'h0, RST_POST_OFFSET}, RST_LOWER_LIMIT,
			RST_UPPER_LIMIT, {16'h0, RST_DEADBAND}, 32'h0000_0000};
		{fails, checks, cyc} = '0;
		{hsel, hwrite, enc_a, enc_b} = '0;
		ce = 1'b1;
		{haddr, hwdata} = '0;
		htrans = 2'h0;
		ain = '{16'h1111, 16'h2222, 16'h3333, 16'hFFFF};
		rst_in = 1'b1;
		repeat (10) @(posedge clk_in);
		rst_in <= 1'b0;
		for (int i = 0; i < 9; i++) rd(ri[i], rv[i], "reset");
		wr(30'h1C3, 32'h0000_5555);
		rd(30'h1C3, 32'h0000_0000, "unmapped");
		$display("test reset values done");
		wr(IDX_TARGET_INPUT, 32'h0000_03E8);
		out_is(32'h0000_03E8, "register source");
		for (int s = 1; s <= 4; s++) begin
			wr(IDX_SOURCE_SELECT, s);
			out_is({16'h0, ain[s-1]}, "analog source");
		end
		// clock enable low must freeze the whole path
		ce <= 1'b0;
		ain[3] <= 16'h4444;
		repeat (12) @(posedge clk_in);
		`CHK("frozen", 32'h0000_FFFF, tgt)
		ce <= 1'b1;
		out_is(32'h0000_4444, "thawed");
		wr(IDX_SOURCE_SELECT, {16'h0, SEL_PULSE});
		out_is(32'h0000_4444, "pulse source");
		$display("test sources done");
		wr(IDX_SOURCE_SELECT, {16'h0, SEL_REGISTER});
		wr(IDX_MULTIPLIER, 32'h0000_FFFD);
		rd(IDX_MULTIPLIER, 32'h0000_FFFD, "mul readback");
		wr(IDX_DIVISOR, 32'h0000_0002);
		wr(IDX_POST_OFFSET, 32'h0000_0007);
		out_is(32'hFFFF_FA2B, "scale offset");
		wr(IDX_DIVISOR, 32'h0000_0000);
		wr(IDX_TARGET_INPUT, 32'h0000_07D0);
		out_is(32'hFFFF_FA2B, "zero divisor");
		wr(IDX_DIVISOR, 32'h0000_0001);
		wr(IDX_MULTIPLIER, 32'h0000_0001);
		wr(IDX_POST_OFFSET, 32'h0000_0000);
		out_is(32'h0000_07D0, "unit scale");
		$display("test scaling done");
		wr(IDX_TARGET_INPUT, 32'h0000_03E8);
		wr(IDX_DEADBAND, 32'h0000_000A);
		rd(IDX_DEADBAND, 32'h0000_000A, "deadband readback");
		wr(IDX_TARGET_INPUT, 32'h0000_03ED);
		out_is(32'h0000_03E8, "small change held");
		wr(IDX_TARGET_INPUT, 32'h0000_03FC);
		out_is(32'h0000_03FC, "large change passed");
		wr(IDX_DEADBAND, 32'h0000_0000);
		$display("test deadband done");
		wr(IDX_LOWER_LIMIT, 32'hFFFF_FF9C);
		wr(IDX_UPPER_LIMIT, 32'h0000_0064);
		rd(IDX_LOWER_LIMIT, 32'hFFFF_FF9C, "lower readback");
		wr(IDX_TARGET_INPUT, 32'h0000_01F4);
		out_is(32'h0000_0064, "upper clamp");
		wr(IDX_TARGET_INPUT, 32'hFFFF_FE0C);
		out_is(32'hFFFF_FF9C, "lower clamp");
		wr(IDX_LOWER_LIMIT, RST_LOWER_LIMIT);
		wr(IDX_UPPER_LIMIT, RST_UPPER_LIMIT);
		$display("test limits done");
		wr(IDX_ENCODER_MODE, 32'h0000_0001);
		enc_b <= 1'b1;
		steps(5);
		rd(IDX_ENCODER_COUNT, 32'h0000_0005, "step up");
		wr(IDX_SOURCE_SELECT, {16'h0, SEL_ENCODER});
		out_is(32'h0000_0005, "encoder source");
		enc_b <= 1'b0;
		steps(2);
		out_is(32'h0000_0003, "step down");
		wr(IDX_ENCODER_MODE, 32'h0000_0000);
		bus(1'b0, IDX_ENCODER_COUNT, 32'h0000_0000, c0);
		// a leads b: forward quadrature cycle
		foreach (rv[k]) if (k < 4) begin
			{enc_a, enc_b} <= (k == 0) ? 2'h2 : (k == 1) ? 2'h3 :
				(k == 2) ? 2'h1 : 2'h0;
			repeat (4) @(posedge clk_in);
		end
		bus(1'b0, IDX_ENCODER_COUNT, 32'h0000_0000, q);
		`CHK("quadrature up", c0 + 32'h0000_0004, q)
		$display("test encoder done");
		close_out();
	end

endmodule : tb_target_conditioning
